// file: src/ptw_defines.svh
`ifndef PTW_DEFINES_SVH
`define PTW_DEFINES_SVH

// ************************************************************
// Command codes
// ************************************************************
`define PTW_CMD_WARN_LIMIT 8'h51
`define PTW_CMD_TURN_ON_DELAY  8'h60
`define PTW_CMD_SOFT_START_RISE_TIME   8'h61

// ************************************************************
// Reset values and field layout
// ************************************************************
`define PTW_WARN_RESET     11'h078
`define PTW_DELAY_RESET    7'h00
`define PTW_RISE_RESET     7'h03
`define PTW_EXP_ZERO       5'h00
`define PTW_UPPER_ZERO     4'h0
`define PTW_DLO_BIT        4

// ************************************************************
// Warning limit arithmetic
// ************************************************************
`define PTW_WARN_HYST      12'h014
`define PTW_WARN_OFFSET    11'h019
`define PTW_WARN_MIN       11'h064
`define PTW_WARN_MAX       11'h08c

// ************************************************************
// Timing
// ************************************************************
`define PTW_DELAY_ZERO_US  17'h00032
`define PTW_US_PER_MS      17'h003e8
`define PTW_RISE_ZERO_MS   7'h01
`define PTW_SETTLE_CYCLES  2'h3

`endif

// file: src/ptw_pkg.sv
package ptw_pkg;

  // Command as handed over by the PMBus transaction layer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } ptw_cmd_t;

  // Answer to one command
  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [15:0] rdata;
  } ptw_rsp_t;

  // Sticky status bits owned by this bank
  typedef struct packed {
    logic tempSummary;
    logic tempWarn;
    logic commError;
    logic invalidData;
    logic invalidCmd;
  } ptw_status_t;

  typedef enum logic [1:0] {
    PTW_PU_WAIT_NVM = 2'b00,
    PTW_PU_SETTLE   = 2'b01,
    PTW_PU_RUN      = 2'b10
  } ptw_pu_state_t;

endpackage : ptw_pkg

// file: src/ptw_sync3.sv
`timescale 1ns/1ps

module ptw_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Asynchronous level in, settled level out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Q;
  logic [WIDTH-1:0] stage2Q;
  logic [WIDTH-1:0] stage3Q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1Q <= '0;
      stage2Q <= '0;
      stage3Q <= '0;
    end
    else
    begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
    end
  end

  // A change counts only once two later stages agree
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      syncOut <= '0;
    else if (stage2Q == stage3Q)
      syncOut <= stage3Q;
  end

endmodule : ptw_sync3

// file: src/ptw_bucket_map.sv
`timescale 1ns/1ps

module ptw_bucket_map (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Programmed mantissa in, bucket time in ms out
  input  wire logic [6:0] mantissa,
  output logic      [6:0] effMs
);

  // Upper edge of each bucket and the time that bucket selects
  localparam logic [6:0] LIMIT [16] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h09,
    7'h0c, 7'h11, 7'h16, 7'h20, 7'h2c, 7'h3e, 7'h56, 7'h7f};
  localparam logic [6:0] VALUE [16] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
    7'h0a, 7'h0e, 7'h13, 7'h1b, 7'h25, 7'h34, 7'h48, 7'h64};

  logic [6:0] pick;

  // Scan from the top so the lowest matching bucket wins
  always_comb
  begin
    pick = VALUE[15];
    for (int i = 15; i >= 0; i--)
    begin
      if (mantissa <= LIMIT[i])
        pick = VALUE[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      effMs <= 7'h00;
    else
      effMs <= pick;
  end

endmodule : ptw_bucket_map

// file: src/ptw_regbank.sv
// Summary of operation
// - A sensed temperature above the warning limit sets the temperature summary and warning status bits and asserts the alert.
// - The tripped warning stays latched until the temperature has dropped 20 degrees below the limit.
// - A warning-limit write at or above the fault limit is dropped and sets comm-error, invalid-data and the alert.
// - With the data-limit override bit 4 of the vendor config set, warning-limit writes skip the fault-limit check.
// - The default warning limit is the fault limit minus 25, never below 100.
// - The warning-limit exponent reads as zero and cannot be written; only the mantissa is programmable.
// - The warning-limit mantissa resets to 120 and its range is 100 to 140.
// - The turn-on delay register holds milliseconds from start to output rise and is handed out on store-all.
// - On a loop slave the delay and rise commands are NACKed, raise an invalid-command fault and the alert, and writes are lost.
// - The turn-on delay keeps its upper four mantissa bits and exponent at zero, seven low bits writable, reset zero.
// - The delay mantissa maps into one of 16 buckets, and zero gives an effective 50 us.
// - The rise-time register holds milliseconds of reference ramp and is handed out on store-all.
// - A rise time of zero gives the fastest ramp, an effective one millisecond.
// - When the soft-start pin is not high, the strap mantissa overwrites the restored rise time at power-up.
// - The rise-time mantissa keeps its upper four bits at zero, seven low bits writable, default three.
`timescale 1ns/1ps
`include "ptw_defines.svh"

module ptw_regbank (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Command port
  input  wire ptw_pkg::ptw_cmd_t    cmdIn,
  output ptw_pkg::ptw_rsp_t         rspOut,
  // Temperature and limits
  input  wire logic [10:0]          sensedTemp,
  input  wire logic [10:0]          tempFaultLimit,
  input  wire logic [7:0]           vendorConfig,
  input  wire logic                 clearFaults,
  // Straps
  input  wire logic                 loopSlavePin,
  input  wire logic                 ssPinHigh,
  input  wire logic [6:0]           ssStrapMantissa,
  // Nonvolatile store and restore
  input  wire logic                 nvmRestoreValid,
  input  wire logic [6:0]           nvmTonDelay,
  input  wire logic [6:0]           nvmTonRise,
  input  wire logic                 storeAllReq,
  output logic                      nvmStoreValid,
  output logic [6:0]                nvmStoreDelay,
  output logic [6:0]                nvmStoreRise,
  // Status
  output ptw_pkg::ptw_status_t      statusOut,
  output logic                      smbAlert_n,
  output logic                      warnActive,
  // Effective start-up times
  output logic [16:0]               effDelayUs,
  output logic [6:0]                effRiseMs
);

  import ptw_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  ptw_pu_state_t puState_q;
  ptw_pu_state_t puState_d;
  logic [1:0]    settle_q;
  logic [10:0]   warnLimit_q;
  logic [6:0]    tonDelay_q;
  logic [6:0]    tonRise_q;
  logic [1:0]    strapSync;
  logic          loopSlave;
  logic          ssHigh;
  logic [6:0]    delayBucketMs;
  logic [6:0]    riseBucketMs;
  logic [16:0]   delayMsWide;
  ptw_status_t   status_d;

  logic          running;
  logic          isWarn;
  logic          isDelay;
  logic          isRise;
  logic          ours;
  logic          locked;
  logic          take;
  logic          doWrite;
  logic [10:0]   warnMant;
  logic          warnBad;
  logic          data_limit_override;
  logic [10:0]   warnDefault;
  logic          restoreNow;
  logic          strapNow;
  logic [11:0]   tempExt;
  logic [11:0]   limitExt;
  logic [11:0]   releaseLvl;
  logic          trip;
  logic          relWarn;
  logic          setInvData;
  logic          setInvCmd;

  // ************************************************************
  // Strap synchronisers and bucket decoders
  // ************************************************************
  ptw_sync3 #(
    .WIDTH (2)
  ) u_strapSync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn ({loopSlavePin, ssPinHigh}),
    .syncOut (strapSync)
  );

  assign loopSlave = strapSync[1];
  assign ssHigh    = strapSync[0];

  ptw_bucket_map u_delayMap (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .mantissa (tonDelay_q),
    .effMs    (delayBucketMs)
  );

  ptw_bucket_map u_riseMap (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .mantissa (tonRise_q),
    .effMs    (riseBucketMs)
  );

  // ************************************************************
  // Power-up sequencing
  // ************************************************************
  always_comb
  begin
    puState_d = puState_q;
    case (puState_q)
      PTW_PU_WAIT_NVM:
        if (nvmRestoreValid)
          puState_d = PTW_PU_SETTLE;
      PTW_PU_SETTLE:
        if (settle_q == `PTW_SETTLE_CYCLES)
          puState_d = PTW_PU_RUN;
      PTW_PU_RUN:
        puState_d = PTW_PU_RUN;
      default:
        puState_d = PTW_PU_WAIT_NVM;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      puState_q <= PTW_PU_WAIT_NVM;
    else
      puState_q <= puState_d;
  end

  // Strap levels need a few cycles through the synchroniser
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      settle_q <= 2'h0;
    else if (puState_q == PTW_PU_SETTLE && settle_q != `PTW_SETTLE_CYCLES)
      settle_q <= settle_q + 2'h1;
  end

  assign running    = (puState_q == PTW_PU_RUN);
  assign restoreNow = (puState_q == PTW_PU_WAIT_NVM) && nvmRestoreValid;
  assign strapNow   = (puState_q == PTW_PU_SETTLE) &&
                      (settle_q == `PTW_SETTLE_CYCLES) && !ssHigh;

  // Underflow of the subtraction is avoided by the compare
  assign warnDefault =
    (tempFaultLimit < (`PTW_WARN_MIN + `PTW_WARN_OFFSET)) ?
    `PTW_WARN_MIN : tempFaultLimit - `PTW_WARN_OFFSET;

  // ************************************************************
  // Command decode
  // ************************************************************
  assign isWarn   = (cmdIn.code == `PTW_CMD_WARN_LIMIT);
  assign isDelay  = (cmdIn.code == `PTW_CMD_TURN_ON_DELAY);
  assign isRise   = (cmdIn.code == `PTW_CMD_SOFT_START_RISE_TIME);
  assign ours     = isWarn || isDelay || isRise;
  assign locked   = loopSlave && (isDelay || isRise);
  assign take     = cmdIn.valid && ours;
  assign doWrite  = take && cmdIn.write && running && !locked;
  assign data_limit_override      = vendorConfig[`PTW_DLO_BIT];
  assign warnMant = cmdIn.wdata[10:0];

  // Override skips every limit check, range included
  assign warnBad = !data_limit_override &&
                   ((warnMant >= tempFaultLimit) ||
                    (warnMant < `PTW_WARN_MIN) ||
                    (warnMant > `PTW_WARN_MAX));

  assign setInvData = doWrite && isWarn && warnBad;
  assign setInvCmd  = take && running && locked;

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      warnLimit_q <= `PTW_WARN_RESET;
    else if (restoreNow)
      warnLimit_q <= warnDefault;
    else if (doWrite && isWarn && !warnBad)
      warnLimit_q <= warnMant;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tonDelay_q <= `PTW_DELAY_RESET;
    else if (restoreNow)
      tonDelay_q <= nvmTonDelay;
    else if (doWrite && isDelay)
      tonDelay_q <= cmdIn.wdata[6:0];
  end

  // Strap load comes after the restore, so it wins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tonRise_q <= `PTW_RISE_RESET;
    else if (restoreNow)
      tonRise_q <= nvmTonRise;
    else if (strapNow)
      tonRise_q <= ssStrapMantissa;
    else if (doWrite && isRise)
      tonRise_q <= cmdIn.wdata[6:0];
  end

  // ************************************************************
  // Response
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rspOut <= '0;
    else
    begin
      rspOut.valid <= take;
      rspOut.nack  <= take && (locked || !running);
      // A refused read before start-up must not leak register contents
      if (!take || locked || !running || cmdIn.write)
        rspOut.rdata <= 16'h0000;
      else if (isWarn)
        rspOut.rdata <= {`PTW_EXP_ZERO, warnLimit_q};
      else if (isDelay)
        rspOut.rdata <= {`PTW_EXP_ZERO, `PTW_UPPER_ZERO,
                         tonDelay_q};
      else
        rspOut.rdata <= {`PTW_EXP_ZERO, `PTW_UPPER_ZERO,
                         tonRise_q};
    end
  end

  // ************************************************************
  // Overtemperature warning with hysteresis
  // ************************************************************
  assign tempExt    = {sensedTemp[10], sensedTemp};
  assign limitExt   = {1'b0, warnLimit_q};
  assign releaseLvl = limitExt - `PTW_WARN_HYST;
  assign trip    = running && !warnActive &&
                   ($signed(tempExt) > $signed(limitExt));
  assign relWarn = warnActive &&
                   ($signed(tempExt) <= $signed(releaseLvl));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      warnActive <= 1'b0;
    else if (trip)
      warnActive <= 1'b1;
    else if (relWarn)
      warnActive <= 1'b0;
  end

  // ************************************************************
  // Sticky status and alert
  // ************************************************************
  // A set in the clearing cycle survives; a latched warning
  // keeps re-setting its bits until the hysteresis lets go
  always_comb
  begin
    status_d.tempSummary = trip || warnActive ||
                           (statusOut.tempSummary && !clearFaults);
    status_d.tempWarn    = trip || warnActive ||
                           (statusOut.tempWarn && !clearFaults);
    status_d.commError   = setInvData || setInvCmd ||
                           (statusOut.commError && !clearFaults);
    status_d.invalidData = setInvData ||
                           (statusOut.invalidData && !clearFaults);
    status_d.invalidCmd  = setInvCmd ||
                           (statusOut.invalidCmd && !clearFaults);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      statusOut <= '0;
    else
      statusOut <= status_d;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      smbAlert_n <= 1'b1;
    else
      smbAlert_n <= ~(|status_d);
  end

  // ************************************************************
  // Store-all hand-off
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvmStoreValid <= 1'b0;
      nvmStoreDelay <= `PTW_DELAY_RESET;
      nvmStoreRise  <= `PTW_RISE_RESET;
    end
    else
    begin
      nvmStoreValid <= storeAllReq && running;
      if (storeAllReq && running)
      begin
        nvmStoreDelay <= tonDelay_q;
        nvmStoreRise  <= tonRise_q;
      end
    end
  end

  // ************************************************************
  // Effective start-up times
  // ************************************************************
  assign delayMsWide = {10'h000, delayBucketMs};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      effDelayUs <= `PTW_DELAY_ZERO_US;
      effRiseMs  <= `PTW_RISE_RESET;
    end
    else
    begin
      if (delayBucketMs == 7'h00)
        effDelayUs <= `PTW_DELAY_ZERO_US;
      else
        effDelayUs <= delayMsWide * `PTW_US_PER_MS;
      if (riseBucketMs == 7'h00)
        effRiseMs <= `PTW_RISE_ZERO_MS;
      else
        effRiseMs <= riseBucketMs;
    end
  end

endmodule : ptw_regbank

// file: tb/ptw_regbank_assertions.sv
`timescale 1ns/1ps
`include "ptw_defines.svh"

module ptw_regbank_assertions (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // Command port
  input wire ptw_pkg::ptw_cmd_t    cmdIn,
  input wire ptw_pkg::ptw_rsp_t    rspOut,
  // Controls
  input wire logic [10:0]          tempFaultLimit,
  input wire logic [7:0]           vendorConfig,
  input wire logic                 loopSlavePin,
  input wire logic                 storeAllReq,
  // Results
  input wire logic                 nvmStoreValid,
  input wire ptw_pkg::ptw_status_t statusOut,
  input wire logic                 smbAlert_n,
  input wire logic                 warnActive,
  input wire logic [16:0]          effDelayUs,
  input wire logic [6:0]           effRiseMs
);
  import ptw_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_warnFlags;
    warnActive |-> statusOut.tempWarn && statusOut.tempSummary;
  endproperty
  a_warnFlags: assert property (p_warnFlags)
    else $error("warning without status bits");

  property p_alert;
    smbAlert_n == !(|statusOut);
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert does not follow status");

  property p_badWarn;
    cmdIn.valid && cmdIn.write && cmdIn.code == `PTW_CMD_WARN_LIMIT &&
      !vendorConfig[`PTW_DLO_BIT] && cmdIn.wdata[10:0] >= tempFaultLimit
      |=> rspOut.valid &&
          (rspOut.nack || statusOut.invalidData && statusOut.commError);
  endproperty
  a_badWarn: assert property (p_badWarn)
    else $error("bad limit write not flagged");

  // Pin high now and eight cycles back, taken as settled through the synchroniser
  property p_slave;
    cmdIn.valid && cmdIn.code inside {`PTW_CMD_TURN_ON_DELAY, `PTW_CMD_SOFT_START_RISE_TIME}
      && loopSlavePin && $past(loopSlavePin, 8)
      |=> rspOut.valid && rspOut.nack;
  endproperty
  a_slave: assert property (p_slave)
    else $error("loop slave command not refused");

  property p_nackData;
    rspOut.nack |-> rspOut.rdata == 16'h0000;
  endproperty
  a_nackData: assert property (p_nackData)
    else $error("refused answer carries data");

  property p_expZero;
    rspOut.valid |-> rspOut.rdata[15:11] == `PTW_EXP_ZERO;
  endproperty
  a_expZero: assert property (p_expZero)
    else $error("exponent not zero");

  property p_upperZero;
    rspOut.valid && $past(cmdIn.code) != `PTW_CMD_WARN_LIMIT
      |-> rspOut.rdata[15:7] == 9'h000;
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("timing word upper bits not zero");

  property p_delayStep;
    effDelayUs == `PTW_DELAY_ZERO_US || effDelayUs % `PTW_US_PER_MS == 0;
  endproperty
  a_delayStep: assert property (p_delayStep)
    else $error("effective delay off the grid");

  property p_riseRange;
    effRiseMs != 7'h00 && effRiseMs <= 7'h64;
  endproperty
  a_riseRange: assert property (p_riseRange)
    else $error("effective rise time out of range");

  property p_store;
    nvmStoreValid |-> $past(storeAllReq) ##1 !nvmStoreValid;
  endproperty
  a_store: assert property (p_store)
    else $error("store pulse without request");
endmodule : ptw_regbank_assertions

// file: tb/ptw_host_model.sv
`timescale 1ns/1ps

module ptw_host_model (
  // Clock
  input wire logic          mclk,
  // Command to the bank
  output ptw_pkg::ptw_cmd_t cmdOut
);
  import ptw_pkg::*;

  initial cmdOut = '0;

  // Limit values that break the fault ordering come only from the caller
  task automatic send(input logic wr, input logic [7:0] code,
                      input logic [15:0] data);
    @(posedge mclk);
    cmdOut <= '{valid: 1'b1, write: wr, code: code, wdata: data};
  endtask : send

  // Released write and data lines show the inverse of the last word, never a stale copy; valid and code go to zero
  task automatic idle();
    @(posedge mclk);
    cmdOut <= '{valid: 1'b0, write: ~cmdOut.write, code: 8'h00,
                wdata: ~cmdOut.wdata};
  endtask : idle
endmodule : ptw_host_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "ptw_defines.svh"

module tb_top;
  import ptw_pkg::*;

  logic        mclk, rst_n, clearFaults, loopSlavePin, ssPinHigh;
  logic        nvmRestoreValid, storeAllReq, nvmStoreValid;
  logic        smbAlert_n, warnActive;
  logic [10:0] sensedTemp, tempFaultLimit;
  logic [7:0]  vendorConfig;
  logic [6:0]  ssStrapMantissa, nvmTonDelay, nvmTonRise;
  logic [6:0]  nvmStoreDelay, nvmStoreRise, effRiseMs, md, mr;
  logic [16:0] effDelayUs;
  ptw_cmd_t    cmdIn;
  ptw_rsp_t    rspOut;
  ptw_status_t statusOut;
  ptw_rsp_t    expQ[$];
  int          errCount, nTests, cycles, seed;
  logic [6:0]  vals[4] = '{7'h00, 7'h56, 7'h57, 7'h7f};

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  ptw_host_model ptw_host_model_inst (.mclk(mclk), .cmdOut(cmdIn));

  ptw_regbank ptw_regbank_inst (
    .mclk(mclk), .rst_n(rst_n), .cmdIn(cmdIn), .rspOut(rspOut),
    .sensedTemp(sensedTemp), .tempFaultLimit(tempFaultLimit),
    .vendorConfig(vendorConfig), .clearFaults(clearFaults),
    .loopSlavePin(loopSlavePin), .ssPinHigh(ssPinHigh),
    .ssStrapMantissa(ssStrapMantissa), .nvmRestoreValid(nvmRestoreValid),
    .nvmTonDelay(nvmTonDelay), .nvmTonRise(nvmTonRise),
    .storeAllReq(storeAllReq), .nvmStoreValid(nvmStoreValid),
    .nvmStoreDelay(nvmStoreDelay), .nvmStoreRise(nvmStoreRise),
    .statusOut(statusOut), .smbAlert_n(smbAlert_n),
    .warnActive(warnActive), .effDelayUs(effDelayUs),
    .effRiseMs(effRiseMs));

  // ************************************************************
  // Checking
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    $display("mismatches %0d comparisons %0d", errCount, nTests);
    if (errCount == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finishTest

  function automatic int bucketMs(input logic [6:0] m);
    int brk[16] = '{0, 1, 2, 3, 4, 5, 6, 9, 12, 17, 22, 32, 44, 62, 86, 127};
    int ms[16] = '{1, 1, 2, 3, 4, 5, 6, 7, 10, 14, 19, 27, 37, 52, 72, 100};
    bucketMs = 100;
    for (int i = 15; i >= 0; i--)
      if (m <= brk[i])
        bucketMs = ms[i];
  endfunction : bucketMs

  always @(negedge mclk)
    if (rspOut.valid === 1'b1)
    begin
      if (expQ.size() == 0)
        check("spare answer", 1, 0);
      else
        check("answer", rspOut, expQ.pop_front());
    end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      finishTest();
    end
  end

  // ************************************************************
  // Stimulus
  // ************************************************************
  task automatic hostCmd(input logic wr, input logic [7:0] code,
                         input logic [15:0] data, input logic nack,
                         input logic [15:0] rd);
    expQ.push_back('{valid: 1'b1, nack: nack, rdata: rd});
    ptw_host_model_inst.send(wr, code, data);
  endtask : hostCmd

  // Look right after the taking edge: the store strobe stands one cycle
  task automatic pulse(input logic store);
    @(posedge mclk);
    if (store)
      storeAllReq <= 1'b1;
    else
      clearFaults <= 1'b1;
    @(posedge mclk);
    {storeAllReq, clearFaults} <= 2'b00;
    @(negedge mclk);
  endtask : pulse

  task automatic powerUp(input logic slave, input logic ss,
                         input logic [10:0] fault, input logic [6:0] rise);
    @(posedge mclk);
    rst_n <= 1'b0;
    loopSlavePin <= slave;
    ssPinHigh <= ss;
    tempFaultLimit <= fault;
    nvmTonRise <= rise;
    repeat (4) @(posedge mclk);
    check("reset rise", effRiseMs, 7'h03);
    check("reset delay", effDelayUs, `PTW_DELAY_ZERO_US);
    check("reset status", {smbAlert_n, statusOut}, 6'h20);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    nvmRestoreValid <= 1'b1;
    @(posedge mclk);
    nvmRestoreValid <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : powerUp

  task automatic setTemp(input logic [10:0] t, input logic exp);
    @(posedge mclk);
    sensedTemp <= t;
    repeat (3) @(negedge mclk);
    check("warning", warnActive, exp);
  endtask : setTemp

  initial
  begin
    seed = 32'h6c5d;
    rst_n = 1'b0;
    {clearFaults, loopSlavePin, ssPinHigh} = 3'b000;
    {nvmRestoreValid, storeAllReq, vendorConfig} = '0;
    sensedTemp = 11'd25;
    tempFaultLimit = 11'd130;
    ssStrapMantissa = 7'd10;
    nvmTonDelay = 7'd9;
    nvmTonRise = 7'd5;
    // Strap in use: it replaces the restored rise time
    powerUp(1'b0, 1'b0, 11'd130, 7'd5);
    hostCmd(0, `PTW_CMD_WARN_LIMIT, 16'h0, 0, 16'h0069);
    hostCmd(0, `PTW_CMD_TURN_ON_DELAY, 16'h0, 0, 16'h0009);
    hostCmd(0, `PTW_CMD_SOFT_START_RISE_TIME, 16'h0, 0, 16'h000a);
    hostCmd(1, `PTW_CMD_WARN_LIMIT, 16'hf882, 0, 16'h0);
    hostCmd(1, `PTW_CMD_WARN_LIMIT, 16'h0063, 0, 16'h0);
    hostCmd(0, `PTW_CMD_WARN_LIMIT, 16'h0, 0, 16'h0069);
    ptw_host_model_inst.idle();
    @(negedge mclk);
    check("bad write", {smbAlert_n, statusOut}, 6'h06);
    pulse(1'b0);
    check("cleared", {smbAlert_n, statusOut}, 6'h20);
    vendorConfig <= 8'h10;
    hostCmd(1, `PTW_CMD_WARN_LIMIT, 16'h0082, 0, 16'h0);
    hostCmd(0, `PTW_CMD_WARN_LIMIT, 16'h0, 0, 16'h0082);
    ptw_host_model_inst.idle();
    vendorConfig <= 8'h00;
    @(negedge mclk);
    check("override", statusOut, 5'h00);
    hostCmd(1, `PTW_CMD_WARN_LIMIT, 16'hf878, 0, 16'h0);
    hostCmd(0, `PTW_CMD_WARN_LIMIT, 16'h0, 0, 16'h0078);
    for (int i = 0; i < 6; i++)
    begin
      md = (i < 4) ? vals[i] : $random(seed);
      mr = 7'h7f - md;
      hostCmd(1, `PTW_CMD_TURN_ON_DELAY, {$random(seed)} & 16'hff80 | md, 0, 0);
      hostCmd(1, `PTW_CMD_SOFT_START_RISE_TIME, {9'h1ff, mr}, 0, 16'h0);
      hostCmd(0, `PTW_CMD_TURN_ON_DELAY, 16'h0, 0, {9'h0, md});
      hostCmd(0, `PTW_CMD_SOFT_START_RISE_TIME, 16'h0, 0, {9'h0, mr});
      ptw_host_model_inst.idle();
      repeat (3) @(negedge mclk);
      check("eff delay", effDelayUs,
            (md == 0) ? 50 : bucketMs(md) * 1000);
      check("eff rise", effRiseMs, bucketMs(mr));
    end
    pulse(1'b1);
    check("store", {nvmStoreValid, nvmStoreDelay, nvmStoreRise},
          {1'b1, md, mr});
    setTemp(11'd120, 1'b0);
    setTemp(11'd121, 1'b1);
    check("trip", {smbAlert_n, statusOut}, 6'h18);
    setTemp(11'd101, 1'b1);
    setTemp(11'd100, 1'b0);
    pulse(1'b0);
    check("released", {smbAlert_n, statusOut}, 6'h20);
    // Loop slave without strap: clamped default, timing commands refused
    powerUp(1'b1, 1'b1, 11'd110, 7'd7);
    check("no strap", effRiseMs, 7'd7);
    hostCmd(0, `PTW_CMD_TURN_ON_DELAY, 16'h0, 1, 16'h0);
    hostCmd(1, `PTW_CMD_SOFT_START_RISE_TIME, 16'h0001, 1, 16'h0);
    hostCmd(0, `PTW_CMD_WARN_LIMIT, 16'h0, 0, 16'h0064);
    ptw_host_model_inst.idle();
    repeat (3) @(negedge mclk);
    check("slave", {smbAlert_n, statusOut}, 6'h05);
    check("slave rise", effRiseMs, 7'd7);
    check("queue", expQ.size(), 0);
    finishTest();
  end
endmodule : tb_top

bind ptw_regbank ptw_regbank_assertions ptw_regbank_assertions_inst (
  .mclk(mclk), .rst_n(rst_n), .cmdIn(cmdIn), .rspOut(rspOut),
  .tempFaultLimit(tempFaultLimit), .vendorConfig(vendorConfig),
  .loopSlavePin(loopSlavePin), .storeAllReq(storeAllReq),
  .nvmStoreValid(nvmStoreValid), .statusOut(statusOut),
  .smbAlert_n(smbAlert_n), .warnActive(warnActive),
  .effDelayUs(effDelayUs), .effRiseMs(effRiseMs));
